// ===== sscd_decoder.v
// SPI sensor command decoder: frame receive, checks and response
// How it works
// - Accel-select bit 1 means an acceleration data request.
// - Axis 0 gives cancelled or raw data by offset select; axis 1 invalid.
// - Signed bit matches config bit 4, output bit matches bit 2 OR bit 1.
// - Mismatch flags request mismatch and sends no acceleration data.
// - Acceleration commands must hold an odd count of ones.
// - Accel data only with no init, reset, internal or other errors.
// - Accel-select bit 0 means a register access.
// - Access select 0 reads, 1 writes.
// - Register access commands must hold an odd count of ones.
// - Write carries address in bits 12..8 and data in 7..0.
// - Write answered valid only with no errors and lock clear or control address.
// - With lock set only the device control register is writable.
// - Register writes happen after the frame ends.
// - An SPI error in the frame discards the write.
// - Read carries address in bits 12..8, data bits zero.
// - Read contents returned only with no errors.
// - Rising edge count other than sixteen is an SPI error.
// - Invalid accel request answered once, not recorded as a fault.
`timescale 1ns/1ps
`default_nettype none
`include "sscd_regs.vh"
module sscd_decoder
#(
    parameter FRAME_BITS = `SSCD_FRAME_BITS,
    parameter [4:0] CTL_ADDR = 5'h00
)
(
    input wire clk,
    input wire nrst,
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    output reg miso,
    output wire miso_oe,
    input wire [7:0] device_configuration,
    input wire config_lock_bit,
    input wire init_pending_flag,
    input wire reset_occurred_flag,
    input wire internal_error_flag,
    input wire self_test_error,
    input wire self_test_active,
    input wire miso_verify_error,
    input wire [4:0] reg_writable_mask_addr,
    input wire addr_writable,
    input wire addr_readable,
    input wire [7:0] reg_read_data,
    input wire [9:0] accel_cancelled,
    input wire [9:0] accel_raw,
    output reg [4:0] reg_addr,
    output reg [7:0] reg_wdata,
    output reg reg_write,
    output reg request_mismatch,
    output reg spi_error
);
    // Pin order in the synchroniser bank: sclk, select, mosi
    localparam PIN_COUNT = 3;
    localparam [PIN_COUNT-1:0] PIN_IDLE = 3'h2;
    wire [PIN_COUNT-1:0] pin_raw;
    wire [PIN_COUNT-1:0] pin_s;
    wire sclk_s;
    wire cs_n_s;
    wire mosi_s;
    reg sclk_d;
    reg cs_d;
    reg [FRAME_BITS-1:0] shift_in;
    reg [FRAME_BITS-1:0] shift_out;
    reg [`SSCD_CNT_W-1:0] edges;
    reg [FRAME_BITS-1:0] next_resp;
    wire [FRAME_BITS-1:0] resp_word;
    wire par_ok;
    wire rsp_par;
    wire rise;
    wire fall;
    wire frame_end;
    wire frame_start;
    wire edge_err;
    wire cmd_err;
    wire is_accel;
    wire is_write;
    wire mism;
    wire [4:0] cmd_addr;
    wire lock_block;
    wire acc_invalid;
    wire acc_blocked;
    wire [1:0] acc_status;
    wire [9:0] acc_word;
    wire write_ok;
    wire read_ok;
    genvar gi;

    // ==========================================================
    // Pin synchronisers
    // Select idles high, so its flops reset high: no false frame edge
    assign pin_raw = {mosi, cs_n, sclk};
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1)
        begin : g_sync
            sscd_sync #(.RST_VAL(PIN_IDLE[gi])) u_sync
            (
                .clk(clk),
                .nrst(nrst),
                .d(pin_raw[gi]),
                .q(pin_s[gi])
            );
        end
    endgenerate
    assign sclk_s = pin_s[0];
    assign cs_n_s = pin_s[1];
    assign mosi_s = pin_s[2];

    // Edge history of the synchronised pins
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_d <= 1'b0;
            cs_d <= 1'b0;
        end
        else
        begin
            sclk_d <= sclk_s;
            cs_d <= ~cs_n_s;
        end
    end

    assign rise = sclk_s & ~sclk_d;
    assign fall = ~sclk_s & sclk_d;
    assign frame_start = ~cs_n_s & ~cs_d;
    assign frame_end = cs_n_s & cs_d;
    // Drive only inside a frame so other slaves can share the line
    assign miso_oe = ~cs_n_s;

    // ==========================================================
    // Receive shifter and edge counter
    // Counter saturates so that 32 extra edges cannot wrap back to 16
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_in <= `SSCD_RSP_IDLE;
            edges <= 5'h00;
        end
        else if (frame_start)
        begin
            edges <= 5'h00;
        end
        else if (~cs_n_s && rise)
        begin
            shift_in <= {shift_in[FRAME_BITS-2:0], mosi_s};
            if (edges != 5'h1F)
                edges <= edges + 5'h01;
        end
    end

    // ==========================================================
    // Command decode
    sscd_parity #(.WIDTH(FRAME_BITS)) u_pin
    (
        .word(shift_in),
        .odd(par_ok)
    );
    assign is_accel = shift_in[`SSCD_BIT_ACCEL];
    assign is_write = shift_in[`SSCD_BIT_AXSEL];
    assign cmd_addr = shift_in[`SSCD_ADDR_HI:`SSCD_ADDR_LO];
    // Sclk high at deselect also counts as a timing fault
    assign edge_err = (edges != FRAME_BITS) | sclk_s;
    // Odd parity for both command kinds; read data bits must be zero
    assign cmd_err = edge_err | ~par_ok |
        (~is_accel & ~is_write &
         (shift_in[`SSCD_DATA_HI:`SSCD_DATA_LO] != `SSCD_ZERO8));
    assign mism = (shift_in[`SSCD_BIT_SIGNED] !=
                   device_configuration[`SSCD_CFG_SIGNED]) |
                  (shift_in[`SSCD_BIT_OUTFN] !=
                   (device_configuration[`SSCD_CFG_OUTFN_A] |
                    device_configuration[`SSCD_CFG_OUTFN_B]));
    assign lock_block = config_lock_bit & (cmd_addr != CTL_ADDR);

    // ==========================================================
    // Outcome of the decoded command, shared by response and write
    // Axis 1 or a configuration mismatch is an invalid accel request
    assign acc_invalid = shift_in[`SSCD_BIT_AXSEL] | mism;
    assign acc_blocked = init_pending_flag | reset_occurred_flag |
        internal_error_flag;
    // Status field of valid data tells whether self-test is running
    assign acc_status = self_test_active ? `SSCD_ST_INTERR :
        `SSCD_ST_INVACC;
    // Offset select 0 picks cancelled data, 1 raw
    assign acc_word = shift_in[`SSCD_BIT_OCSEL] ? accel_raw :
        accel_cancelled;
    // Locked writes other than to the control address are refused,
    // but a pending MISO fault does not stop a write
    assign write_ok = addr_writable & ~lock_block;
    assign read_ok = addr_readable;

    // ==========================================================
    // Response selection for the following frame, in priority order
    always @*
    begin
        next_resp = `SSCD_RSP_IDLE;
        if (cmd_err)
            next_resp = {`SSCD_RSP_ERR_HI, `SSCD_ST_SPIERR, 8'h00};
        else if (miso_verify_error)
            next_resp = {`SSCD_RSP_ERR_HI, `SSCD_ST_MISOERR, 8'h00};
        else if (is_accel)
        begin
            // Axis 1 or config mismatch: invalid, only a mismatch is flagged
            if (acc_invalid)
                next_resp = {3'h6, 1'b0, 2'h0, `SSCD_ST_INVACC, 8'h00};
            else if (acc_blocked)
                next_resp = {3'h6, 1'b0, 2'h0, `SSCD_ST_INTERR, 8'h00};
            else if (self_test_error)
                next_resp = {3'h2, 1'b1, 2'h0, `SSCD_ST_ERR, 8'h00};
            else
            begin
                // Valid data: prefix, status, parity slot, sample
                next_resp = {3'h4, acc_status, 1'b0, acc_word};
            end
        end
        else if (is_write)
        begin
            if (~write_ok)
                next_resp = `SSCD_RSP_INVREG;
            else
                next_resp = {5'h04, 1'b0, 2'h2,
                    shift_in[`SSCD_DATA_HI:`SSCD_DATA_LO]};
        end
        else
        begin
            if (~read_ok)
                next_resp = `SSCD_RSP_INVREG;
            else
                next_resp = {5'h02, 1'b0, 2'h2,
                             reg_read_data};
        end
        // Parity slot left zero here; it is filled in below
        next_resp[`SSCD_RSP_PAR] = 1'b0;
    end

    sscd_parity #(.WIDTH(FRAME_BITS)) u_pout
    (
        .word(next_resp),
        .odd(rsp_par)
    );
    // Slot set when the rest holds an even count, so the total is odd
    assign resp_word = {next_resp[FRAME_BITS-1:`SSCD_RSP_PAR+1], ~rsp_par,
        next_resp[`SSCD_RSP_PAR-1:0]};

    // ==========================================================
    // Frame end: commit write, report flags
    // Write is issued only after deselect and only without SPI error
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_write <= 1'b0;
            reg_addr <= 5'h00;
            reg_wdata <= 8'h00;
            request_mismatch <= 1'b0;
            spi_error <= 1'b0;
        end
        else
        begin
            reg_write <= 1'b0;
            if (frame_end)
            begin
                spi_error <= cmd_err;
                request_mismatch <= ~cmd_err & is_accel & mism;
                reg_addr <= cmd_addr;
                reg_wdata <= shift_in[`SSCD_DATA_HI:`SSCD_DATA_LO];
                // MISO mismatch still lets a valid write complete
                reg_write <= ~cmd_err & ~is_accel & is_write &
                             write_ok;
            end
        end
    end

    // ==========================================================
    // Transmit: the word latched at one frame end goes out in the next
    // First bit is shown at select, the rest after each falling sclk,
    // so each new bit appears three clock cycles after the falling sclk edge
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_out <= `SSCD_RSP_IDLE;
            miso <= 1'b0;
        end
        else if (frame_end)
            shift_out <= resp_word;
        else if (frame_start)
            miso <= shift_out[FRAME_BITS-1];
        else if (~cs_n_s && fall)
        begin
            shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
            miso <= shift_out[FRAME_BITS-2];
        end
    end

    // Spare input kept for pin compatibility; no logic depends on it
    wire unused_ok = |reg_writable_mask_addr;
endmodule // sscd_decoder
`default_nettype wire

// ===== sscd_regs.vh
// Constants for the SPI sensor command decoder
`ifndef SSCD_REGS_VH
`define SSCD_REGS_VH
// ==========================================================
// Command frame fields
`define SSCD_FRAME_BITS 16
`define SSCD_CNT_W 5
`define SSCD_BIT_ACCEL 15
`define SSCD_BIT_AXSEL 14
`define SSCD_BIT_OCSEL 13
`define SSCD_BIT_SIGNED 12
`define SSCD_BIT_OUTFN 11
`define SSCD_ADDR_HI 12
`define SSCD_ADDR_LO 8
`define SSCD_DATA_HI 7
`define SSCD_DATA_LO 0
// ==========================================================
// Configuration fields
`define SSCD_CFG_SIGNED 4
`define SSCD_CFG_OUTFN_A 2
`define SSCD_CFG_OUTFN_B 1
// ==========================================================
// Response prefixes, top three or six bits; parity at bit 10 is added later
`define SSCD_RSP_ACCEL 3'h1
`define SSCD_RSP_INIT 3'h0
`define SSCD_RSP_ACC_ST 3'h2
`define SSCD_RSP_ERR_HI 6'h03
`define SSCD_ST_ERR 2'h3
`define SSCD_ST_INVACC 2'h1
`define SSCD_ST_INTERR 2'h2
`define SSCD_ST_SPIERR 2'h0
`define SSCD_ST_MISOERR 2'h3
`define SSCD_RSP_INVREG 16'h0E00
`define SSCD_RSP_IDLE 16'h0000
`define SSCD_RSP_PAR 10
`define SSCD_ZERO8 8'h00
`endif

// ===== sscd_sync.v
// Two flip-flop synchroniser for one pin input
`timescale 1ns/1ps
`default_nettype none
module sscd_sync
#(
    parameter [0:0] RST_VAL = 1'b0
)
(
    input wire clk,
    input wire nrst,
    input wire d,
    output reg q
);
    reg meta;
    // ==========================================================
    // First stage is read only by the second
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // Reset to the pin's idle level so no false edge follows
            meta <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sscd_sync
`default_nettype wire

// ===== sscd_parity.v
// Odd parity generator for a 16-bit word
`timescale 1ns/1ps
`default_nettype none
module sscd_parity
#(
    parameter WIDTH = 16
)
(
    input wire [WIDTH-1:0] word,
    output wire odd
);
    // High when the word holds an odd number of ones
    assign odd = ^word;
endmodule // sscd_parity
`default_nettype wire

// ===== sscd_chk_assertions.sv
// Port assertions for the SPI command decoder
`timescale 1ns/1ps
`default_nettype none
module sscd_chk
#(
    parameter [4:0] CTL_ADDR = 5'h00
)
(
    input wire clk,
    input wire nrst,
    input wire cs_n,
    input wire miso_oe,
    input wire config_lock_bit,
    input wire [4:0] reg_addr,
    input wire reg_write,
    input wire request_mismatch,
    input wire spi_error
);
    // ==========================================================
    // Frame end relations
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_write_one_pulse: assert property (reg_write |=> !reg_write)
        else $error("write pulse too long");
    a_write_after_end: assert property (reg_write
        |-> cs_n && $past(cs_n, 2))
        else $error("write inside frame");
    a_write_no_err: assert property (reg_write |-> !spi_error)
        else $error("write despite frame error");
    a_lock_ctl_only: assert property (reg_write && config_lock_bit
        |-> reg_addr == CTL_ADDR)
        else $error("locked write done");
    a_err_at_end: assert property ($changed(spi_error)
        |-> cs_n && $past(cs_n, 2))
        else $error("error flag moved in frame");
    a_mism_at_end: assert property ($changed(request_mismatch)
        |-> cs_n && $past(cs_n, 2))
        else $error("mismatch flag moved in frame");
    a_mism_no_write: assert property ($rose(request_mismatch)
        |-> !reg_write)
        else $error("write on accel request");
    a_oe_released: assert property (cs_n [*4] |-> !miso_oe)
        else $error("output driven while idle");
    a_oe_driven: assert property (!cs_n [*4] |-> miso_oe)
        else $error("output not driven in frame");
    c_write: cover property (reg_write);
    c_err: cover property ($rose(spi_error));
    c_mism: cover property ($rose(request_mismatch));
endmodule // sscd_chk
bind sscd_decoder sscd_chk #(.CTL_ADDR(CTL_ADDR)) sscd_chk_i
(
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .miso_oe(miso_oe),
    .config_lock_bit(config_lock_bit), .reg_addr(reg_addr),
    .reg_write(reg_write), .request_mismatch(request_mismatch),
    .spi_error(spi_error)
);
`default_nettype wire

// ===== sscd_host.sv
// SPI master model facing the command decoder
`timescale 1ns/1ps
`default_nettype none
module sscd_host
(
    input wire logic clk,
    input wire logic miso,
    output logic sclk = 1'b0,
    output logic cs_n = 1'b1,
    output logic mosi = 1'b0
);
    logic [15:0] rsp = 16'h0000;
    // ==========================================================
    // One frame, MSB first, 200 ns clock; short count breaks the frame
    task automatic xfer(input logic [15:0] cmd, input int nbits);
        int i;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (i = 0; i < nbits; i++)
        begin
            mosi <= cmd[15 - i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            rsp <= {rsp[14:0], miso};
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        // Clock low before deselect, gap well above four cycles
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask
endmodule // sscd_host
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the SPI command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [4:0] CTL = 5'h00;
    logic clk, nrst, lock, mve, wr_ok, rd_ok, rw, rm, se, a, ax, sd, fn;
    logic perr, wexp, mis;
    logic [7:0] cfg, rdat, wd;
    logic [4:0] flg, ra;
    logic [19:0] acc;
    logic [15:0] cmd, ersp, wlat;
    logic [31:0] seed, r, s;
    wire sclk, cs_n, mosi, miso, miso_oe;
    int failures = 0;
    int check_count = 0;
    int n, nb, ek, pb, cycles = 0, wcnt = 0;
    sscd_host sscd_host_i
    (
        .clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi)
    );
    sscd_decoder #(.CTL_ADDR(CTL)) sscd_decoder_i
    (
        .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .device_configuration(cfg),
        .config_lock_bit(lock), .init_pending_flag(flg[0]),
        .reset_occurred_flag(flg[1]), .internal_error_flag(flg[2]),
        .self_test_error(flg[3]), .self_test_active(flg[4]),
        .miso_verify_error(mve), .reg_writable_mask_addr(5'h00),
        .addr_writable(wr_ok), .addr_readable(rd_ok), .reg_read_data(rdat),
        .accel_cancelled(acc[9:0]), .accel_raw(acc[19:10]),
        .reg_addr(ra), .reg_wdata(wd), .reg_write(rw),
        .request_mismatch(rm), .spi_error(se)
    );
    // ==========================================================
    // Clock, write monitor and hang guard
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (rw === 1'b1)
        begin
            wcnt++;
            wlat = {3'h0, ra, wd};
        end
        if (cycles == 20000)
        begin
            failures++;
            summarize;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %0t frame %0d seen %h", $time, n, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // Random frames of every kind, judged against a reference
    initial
    begin
        seed = 32'h0000BDBE;
        ek = 0;
        {nrst, lock, mve, wr_ok, rd_ok, cfg, rdat, flg, acc} = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        for (n = 0; n < 70; n++)
        begin
            seed = lfsr(seed);
            r = seed;
            seed = lfsr(seed);
            s = seed;
            a = r[31];
            ax = s[1] & (s[2] | !a);
            sd = r[4] ^ (s[3] & s[4]);
            fn = (r[2] | r[1]) ^ (s[5] & s[6]);
            mis = (sd != r[4]) || (fn != (r[2] | r[1]));
            pb = a ? 0 : 13;
            if (a)
                cmd = {a, ax, s[0], sd, fn, 11'h000};
            else
                cmd = {a, ax, 1'b0, s[9] ? CTL : s[20:16],
                    (ax | s[7] & s[8]) ? s[15:8] : 8'h00};
            cmd[pb] = ~^cmd;
            cmd[pb] = cmd[pb] ^ (s[21] & s[22]);
            nb = (s[23] & s[24] & s[25]) ? 15 : 16;
            perr = !(^cmd) || nb != 16 || (!a && !ax && cmd[7:0] != 8'h00);
            wexp = !a && ax && !perr && cmd[12:8] != 5'h1F
                && (!r[8] || cmd[12:8] == CTL);
            @(posedge clk);
            cfg <= r[7:0];
            lock <= r[8];
            mve <= r[11:9] == 3'h0;
            flg <= (r[14:12] == 3'h0) ? r[19:15] : 5'h00;
            wr_ok <= cmd[12:8] != 5'h1F;
            rd_ok <= cmd[12:8] != 5'h1E;
            rdat <= r[27:20];
            acc <= s[31:12];
            wcnt = 0;
            sscd_host_i.xfer(cmd, nb);
            check(se, perr);
            check(16'(wcnt), wexp);
            if (wexp)
                check(wlat, {3'h0, cmd[12:0]});
            if (a && !ax && !perr)
                check(rm, mis);
            if (nb == 16 && n > 0)
            begin
                check(^sscd_host_i.rsp, 1'b1);
                if (ek == 1)
                    check(sscd_host_i.rsp, 16'h0E00);
                if (ek == 2)
                    check(sscd_host_i.rsp[7:0], ersp[7:0]);
                if (ek == 3)
                    check(sscd_host_i.rsp[9:0], ersp[9:0]);
            end
            ek = 0;
            if (!perr && !mve && !a)
                ek = (ax ? wexp : rd_ok) ? 2 : 1;
            if (!perr && !mve && a && !ax && flg == 5'h00 && !mis)
                ek = 3;
            ersp = a ? {6'h00, s[0] ? acc[19:10] : acc[9:0]}
                : {8'h00, ax ? cmd[7:0] : rdat};
            $display("frame %0d cmd %h done", n, cmd);
        end
        summarize;
    end
endmodule // testbench
`default_nettype wire
